// ### hdl/dtc_engine.sv
// Command execution engine for six task-file commands.
// Assumes host logic on ref_clk; slave_passed_line is a pin, synchronised.
`timescale 1ns/1ps
module dtc_engine #(
   parameter int DIAG_WAIT = dtc_pkg::DIAG_WAIT_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire dtc_pkg::dtc_taskfile_s taskfile_in,
   input wire logic is_master,
   input wire logic slave_present,
   input wire logic self_test_fail,
   input wire logic slave_passed_line,
   input wire logic data_write,
   input wire logic [15:0] data_wdata,
   input wire logic data_read,
   input wire logic seek_done,
   input wire logic disk_error,
   input wire logic disk_correctable,
   output dtc_pkg::dtc_status_s status,
   output logic [7:0] error_reg,
   output logic irq,
   output logic [15:0] data_rdata,
   output logic seek_start,
   output logic [9:0] seek_cyl,
   output dtc_pkg::dtc_taskfile_s taskfile_out,
   output logic translate_mode,
   output logic [7:0] sectors_per_track,
   output logic [3:0] max_head
);
   dtc_pkg::dtc_state_e state_ff, nxt_state;
   dtc_pkg::dtc_status_s status_ff;
   dtc_pkg::dtc_taskfile_s tf_ff;
   logic [7:0] err_ff, pend_cmd_ff;
   logic irq_ff, seek_start_ff, seeking_ff, xlate_ff;
   logic [9:0] seek_cyl_ff;
   logic [7:0] spt_ff;
   logic [3:0] mhead_ff;
   logic [4:0] blk_ff;
   logic mul_en_ff;
   logic [8:0] widx_ff;
   logic [7:0] left_ff, inblk_ff;
   logic [31:0] wait_ff;
   logic pd_s1_ff, pd_s2_ff, stop_ff;
   logic [1:0] sect_kind_ff [dtc_pkg::SECT_MAX];
   logic [dtc_pkg::SECT_MAX-1:0] seen_ff, seen_bad;
   logic fmt_bad_ff;
   // Per-sector state: 0 good, 1 bad, 2 redirected; assigned spares counted
   logic [7:0] spares_used_ff;

   wire cmd_go = (state_ff == dtc_pkg::ST_IDLE) && (cmd_write ||
      (pend_cmd_ff != 8'h00)) && !seeking_ff;
   wire [7:0] cur_cmd = cmd_write ? cmd_code : pend_cmd_ff;
   wire [7:0] cur_opc = (cur_cmd[7:4] == 4'hC || cur_cmd[7:4] == 4'h9) ?
      cur_cmd : {cur_cmd[7:4], 4'h0};
   wire cyl_bad = taskfile_in.cylinder >= dtc_pkg::DEF_CYLS;
   wire head_bad = taskfile_in.head > mhead_ff;
   wire [7:0] snum = data_wdata[15:8];
   wire [7:0] desc = data_wdata[7:0];
   wire word_live = widx_ff < {1'b0, spt_ff};
   wire word_bad = word_live && ((snum == 8'h00) || (snum > spt_ff) ||
      seen_ff[snum[5:0]]);
   wire tail_bad = !word_live && (data_wdata != 16'h0000);
   wire blk_ok = taskfile_in.sector_count inside {8'h01, 8'h02, 8'h04,
      8'h08, 8'h10};
   wire [7:0] blk8 = {3'h0, blk_ff};
   wire [7:0] first_n = (left_ff < blk8) ? left_ff : blk8;
   wire diag_timeout = wait_ff >= DIAG_WAIT[31:0];
   wire tgt_bad = seen_bad[tf_ff.sector_number[5:0]];
   wire last_word = widx_ff == 9'(dtc_pkg::WORDS_PER_BLOCK - 1);

   assign status = status_ff;
   assign error_reg = err_ff;
   assign irq = irq_ff;
   assign data_rdata = 16'h0000;
   assign seek_start = seek_start_ff;
   assign seek_cyl = seek_cyl_ff;
   assign taskfile_out = tf_ff;
   assign translate_mode = xlate_ff;
   assign sectors_per_track = spt_ff;
   assign max_head = mhead_ff;

   for (genvar gi = 0; gi < dtc_pkg::SECT_MAX; gi++) begin : g_bad
      assign seen_bad[gi] = sect_kind_ff[gi] == 2'h1;
   end

   // ---------------------------------------------------------------
   // Slave pass line synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      pd_s1_ff <= slave_passed_line;
      pd_s2_ff <= pd_s1_ff;
   end

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= dtc_pkg::ST_IDLE;
         status_ff <= '0;
         tf_ff <= '0;
         err_ff <= dtc_pkg::ERR_NONE;
         pend_cmd_ff <= 8'h00;
         irq_ff <= 1'b0;
         seek_start_ff <= 1'b0;
         seeking_ff <= 1'b0;
         seek_cyl_ff <= '0;
         xlate_ff <= 1'b1;
         spt_ff <= dtc_pkg::XLATE_SECTORS;
         mhead_ff <= dtc_pkg::DEF_MAX_HEAD;
         blk_ff <= '0;
         mul_en_ff <= 1'b0;
         widx_ff <= '0;
         left_ff <= '0;
         inblk_ff <= '0;
         wait_ff <= '0;
         stop_ff <= 1'b0;
         seen_ff <= '0;
         fmt_bad_ff <= 1'b0;
         spares_used_ff <= '0;
         for (int i = 0; i < dtc_pkg::SECT_MAX; i++) begin
            sect_kind_ff[i] <= 2'h0;
         end
      end else begin
         irq_ff <= 1'b0;
         seek_start_ff <= 1'b0;
         if (seeking_ff && seek_done) begin
            seeking_ff <= 1'b0;
            status_ff.seek_complete <= 1'b1;
         end
         if (cmd_write && (seeking_ff || state_ff != dtc_pkg::ST_IDLE)) begin
            pend_cmd_ff <= cmd_code;
            status_ff.busy_flag <= 1'b1;
         end
         case (state_ff)
            dtc_pkg::ST_IDLE: begin
               if (cmd_go) begin
                  pend_cmd_ff <= 8'h00;
                  tf_ff <= taskfile_in;
                  status_ff.busy_flag <= 1'b1;
                  status_ff.error <= 1'b0;
                  err_ff <= dtc_pkg::ERR_NONE;
                  case (cur_opc)
                     dtc_pkg::CMD_FORMAT: begin
                        if (cyl_bad || head_bad) begin
                           err_ff <= dtc_pkg::ERR_IDNF;
                           status_ff.error <= 1'b1;
                           state_ff <= dtc_pkg::ST_DONE;
                        end else begin
                           status_ff.data_request_flag <= 1'b1;
                           widx_ff <= '0;
                           seen_ff <= '0;
                           fmt_bad_ff <= 1'b0;
                           state_ff <= dtc_pkg::ST_FMT_DATA;
                        end
                     end
                     dtc_pkg::CMD_SEEK: begin
                        // Sector number never examined
                        if (cyl_bad) begin
                           err_ff <= dtc_pkg::ERR_IDNF;
                           status_ff.error <= 1'b1;
                        end else begin
                           seek_start_ff <= 1'b1;
                           seek_cyl_ff <= taskfile_in.cylinder;
                           seeking_ff <= 1'b1;
                           status_ff.seek_complete <= 1'b0;
                        end
                        state_ff <= dtc_pkg::ST_DONE;
                     end
                     dtc_pkg::CMD_DIAG: begin
                        wait_ff <= '0;
                        state_ff <= dtc_pkg::ST_DIAG;
                     end
                     dtc_pkg::CMD_INIT: begin
                        // Geometry stored unchecked
                        xlate_ff <= taskfile_in.sector_count ==
                           dtc_pkg::XLATE_SECTORS;
                        spt_ff <= taskfile_in.sector_count;
                        mhead_ff <= taskfile_in.head;
                        state_ff <= dtc_pkg::ST_DONE;
                     end
                     dtc_pkg::CMD_SETMUL: begin
                        mul_en_ff <= blk_ok;
                        blk_ff <= blk_ok ? taskfile_in.sector_count[4:0] :
                           5'h00;
                        if (!blk_ok && taskfile_in.sector_count != 8'h00) begin
                           err_ff <= dtc_pkg::ERR_ABORT;
                           status_ff.error <= 1'b1;
                        end
                        state_ff <= dtc_pkg::ST_DONE;
                     end
                     dtc_pkg::CMD_RDMUL: begin
                        if (!mul_en_ff) begin
                           err_ff <= dtc_pkg::ERR_ABORT;
                           status_ff.error <= 1'b1;
                           state_ff <= dtc_pkg::ST_DONE;
                        end else begin
                           left_ff <= taskfile_in.sector_count;
                           stop_ff <= 1'b0;
                           state_ff <= dtc_pkg::ST_RD_BLOCK;
                        end
                     end
                     default: begin
                        err_ff <= dtc_pkg::ERR_ABORT;
                        status_ff.error <= 1'b1;
                        state_ff <= dtc_pkg::ST_DONE;
                     end
                  endcase
               end
            end
            dtc_pkg::ST_FMT_DATA: begin
               if (data_write) begin
                  widx_ff <= widx_ff + 9'h001;
                  if (word_live) begin
                     seen_ff[snum[5:0]] <= 1'b1;
                  end
                  if (word_bad || tail_bad) begin
                     fmt_bad_ff <= 1'b1;
                  end
                  if (last_word) begin
                     status_ff.data_request_flag <= 1'b0;
                     state_ff <= dtc_pkg::ST_FMT_APPLY;
                  end
               end
            end
            dtc_pkg::ST_FMT_APPLY: begin
               if (fmt_bad_ff) begin
                  err_ff <= dtc_pkg::ERR_IDNF;
                  status_ff.error <= 1'b1;
               end
               state_ff <= dtc_pkg::ST_DONE;
            end
            dtc_pkg::ST_DIAG: begin
               wait_ff <= wait_ff + 32'h1;
               if (!is_master || !slave_present || pd_s2_ff ||
                  diag_timeout) begin
                  err_ff <= (self_test_fail ? dtc_pkg::DIAG_BUF :
                     dtc_pkg::DIAG_OK) | ((is_master && slave_present &&
                     !pd_s2_ff) ? dtc_pkg::DIAG_SLAVE : 8'h00);
                  tf_ff <= '0;
                  status_ff.error <= 1'b0;
                  state_ff <= dtc_pkg::ST_DONE;
               end
            end
            dtc_pkg::ST_RD_BLOCK: begin
               if (left_ff == 8'h00 || stop_ff) begin
                  status_ff.busy_flag <= pend_cmd_ff != 8'h00 || cmd_write;
                  state_ff <= dtc_pkg::ST_IDLE;
               end else begin
                  inblk_ff <= first_n;
                  widx_ff <= '0;
                  status_ff.data_request_flag <= 1'b1;
                  status_ff.busy_flag <= 1'b0;
                  irq_ff <= 1'b1;
                  if (disk_error || tgt_bad) begin
                     status_ff.error <= 1'b1;
                     err_ff <= tgt_bad ? dtc_pkg::ERR_BADBLK :
                        dtc_pkg::ERR_IDNF;
                     stop_ff <= !disk_correctable || tgt_bad;
                  end
                  state_ff <= dtc_pkg::ST_RD_XFER;
               end
            end
            dtc_pkg::ST_RD_XFER: begin
               if (data_read) begin
                  widx_ff <= last_word ? 9'h000 : widx_ff + 9'h001;
                  if (last_word) begin
                     inblk_ff <= inblk_ff - 8'h01;
                     left_ff <= left_ff - 8'h01;
                     if (tf_ff.sector_number >= spt_ff) begin
                        tf_ff.sector_number <= 8'h01;
                        if (tf_ff.head >= mhead_ff) begin
                           tf_ff.head <= 4'h0;
                           tf_ff.cylinder <= tf_ff.cylinder + 10'h001;
                        end else begin
                           tf_ff.head <= tf_ff.head + 4'h1;
                        end
                     end else begin
                        tf_ff.sector_number <= tf_ff.sector_number + 8'h01;
                     end
                     if (inblk_ff == 8'h01) begin
                        status_ff.data_request_flag <= 1'b0;
                        status_ff.busy_flag <= 1'b1;
                        state_ff <= dtc_pkg::ST_RD_BLOCK;
                     end
                  end
               end
            end
            dtc_pkg::ST_DONE: begin
               status_ff.busy_flag <= pend_cmd_ff != 8'h00 || cmd_write;
               irq_ff <= 1'b1;
               state_ff <= dtc_pkg::ST_IDLE;
            end
            default: state_ff <= dtc_pkg::ST_IDLE;
         endcase
         // Descriptor effects applied per word as it arrives
         if (state_ff == dtc_pkg::ST_FMT_DATA && data_write && word_live &&
            !word_bad) begin
            case (desc)
               dtc_pkg::DESC_GOOD: sect_kind_ff[snum[5:0]] <= 2'h0;
               dtc_pkg::DESC_BAD: sect_kind_ff[snum[5:0]] <= 2'h1;
               dtc_pkg::DESC_ASSIGN: begin
                  sect_kind_ff[snum[5:0]] <= 2'h2;
                  spares_used_ff <= spares_used_ff + 8'h01;
               end
               dtc_pkg::DESC_UNASSIGN: sect_kind_ff[snum[5:0]] <= 2'h0;
               default: sect_kind_ff[snum[5:0]] <= sect_kind_ff[snum[5:0]];
            endcase
         end
      end
   end
endmodule

// ### hdl/dtc_pkg.sv
// Package for the disk track command engine: codes, geometry, timing.
// Assumes a single 40 MHz clock domain.
package dtc_pkg;
   localparam logic [7:0] CMD_FORMAT = 8'h50;
   localparam logic [7:0] CMD_SEEK = 8'h70;
   localparam logic [7:0] CMD_DIAG = 8'h90;
   localparam logic [7:0] CMD_INIT = 8'h91;
   localparam logic [7:0] CMD_RDMUL = 8'hC4;
   localparam logic [7:0] CMD_SETMUL = 8'hC6;
   localparam logic [3:0] CMD_HI_MASK = 4'hF;
   localparam logic [7:0] DESC_GOOD = 8'h00;
   localparam logic [7:0] DESC_BAD = 8'h80;
   localparam logic [7:0] DESC_ASSIGN = 8'h40;
   localparam logic [7:0] DESC_UNASSIGN = 8'h20;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_IDNF = 8'h10;
   localparam logic [7:0] ERR_ABORT = 8'h04;
   localparam logic [7:0] ERR_BADBLK = 8'h80;
   localparam logic [7:0] DIAG_OK = 8'h01;
   localparam logic [7:0] DIAG_BUF = 8'h03;
   localparam logic [7:0] DIAG_SLAVE = 8'h80;
   localparam logic [7:0] XLATE_SECTORS = 8'h11;
   localparam logic [3:0] DEF_MAX_HEAD = 4'h3;
   localparam logic [9:0] DEF_CYLS = 10'h267;
   localparam int WORDS_PER_BLOCK = 256;
   localparam int SECT_MAX = 64;
   localparam int CLK_HZ = 40_000_000;
   localparam int DIAG_WAIT_S = 5;
   localparam int DIAG_WAIT_CYC = DIAG_WAIT_S * CLK_HZ;
   typedef struct packed {
      logic [7:0] sector_count;
      logic [7:0] sector_number;
      logic [9:0] cylinder;
      logic [3:0] head;
   } dtc_taskfile_s;
   typedef struct packed {
      logic busy_flag;
      logic data_request_flag;
      logic error;
      logic seek_complete;
   } dtc_status_s;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_WAITSEEK = 4'h1, ST_FMT_DATA = 4'h2,
      ST_FMT_APPLY = 4'h3, ST_DIAG = 4'h4, ST_RD_BLOCK = 4'h5,
      ST_RD_XFER = 4'h6, ST_DONE = 4'h7
   } dtc_state_e;
endpackage

// ### test/dtc_engine_props.sv
// Checker for the disk track command engine, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module dtc_engine_props #(
   parameter int DIAG_WAIT = 100
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic seek_done,
   input wire dtc_pkg::dtc_status_s status,
   input wire logic [7:0] error_reg,
   input wire logic irq,
   input wire logic [15:0] data_rdata,
   input wire logic seek_start,
   input wire logic translate_mode,
   input wire logic [7:0] sectors_per_track,
   input wire logic [3:0] max_head
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_seek_launch: assert property (seek_start |-> status.busy_flag)
      else $error("seek launched without busy");
   chk_seek_early_irq: assert property (
      seek_start |=> irq && !status.busy_flag)
      else $error("seek did not release busy with an interrupt");
   chk_seek_cmpl_set: assert property (
      seek_done |=> status.seek_complete)
      else $error("seek complete not set after seek end");
   chk_irq_one_cycle: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   chk_reset_geometry: assert property ($fell(reset) |->
      translate_mode && sectors_per_track == dtc_pkg::XLATE_SECTORS
      && max_head == dtc_pkg::DEF_MAX_HEAD)
      else $error("wrong power-up geometry");
   chk_xlate_only_17: assert property (
      translate_mode |-> sectors_per_track == dtc_pkg::XLATE_SECTORS)
      else $error("translate mode without 17 sectors");
   chk_zero_fill_data: assert property (
      status.data_request_flag |-> data_rdata == 16'h0000)
      else $error("sector data not zero");
   chk_idnf_err_flag: assert property (
      irq && error_reg == dtc_pkg::ERR_IDNF |-> status.error)
      else $error("not-found code without error flag");
   chk_irq_not_busy: assert property (
      irq && !status.data_request_flag |-> !status.busy_flag)
      else $error("ending interrupt while busy");

   cov_seek: cover property (seek_start);
   cov_drq: cover property ($rose(status.data_request_flag));
   cov_abort: cover property (irq && error_reg == dtc_pkg::ERR_ABORT);
endmodule

bind dtc_engine dtc_engine_props #(.DIAG_WAIT(DIAG_WAIT)) i_dtc_engine_props (
   .ref_clk(ref_clk), .reset(reset), .seek_done(seek_done),
   .status(status), .error_reg(error_reg), .irq(irq),
   .data_rdata(data_rdata), .seek_start(seek_start),
   .translate_mode(translate_mode), .sectors_per_track(sectors_per_track),
   .max_head(max_head));

// ### test/dtc_host_model.sv
// Host task-file controller model: commands and data-register transfers.
// Assumes the bench calls its tasks; all drives change at falling edges.
`timescale 1ns/1ps
module dtc_host_model (
   input wire logic ref_clk,
   input wire dtc_pkg::dtc_status_s status,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output dtc_pkg::dtc_taskfile_s taskfile_in,
   output logic data_write,
   output logic [15:0] data_wdata,
   output logic data_read
);
   initial begin
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      taskfile_in = '0;
      data_write = 1'b0;
      data_wdata = 16'h0000;
      data_read = 1'b0;
   end

   task automatic send_cmd(input logic [7:0] code, input logic [7:0] cnt,
         input logic [9:0] cyl, input logic [3:0] head);
      int n;
      n = 0;
      while (status.busy_flag !== 1'b0 && n < 1000) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      cmd_code = code;
      taskfile_in = {cnt, 8'h01, cyl, head};
      cmd_write = 1'b1;
      @(negedge ref_clk);
      cmd_write = 1'b0;
   endtask

   // Sectors 3, 4 and 5 carry bad, assign and unassign when mixed is set
   task automatic write_block(input int nsect, input logic mixed);
      logic [7:0] s;
      logic [7:0] d;
      for (int i = 0; i < 256; i++) begin
         s = 8'(i + 1);
         d = !mixed ? dtc_pkg::DESC_GOOD : s == 8'h03 ? dtc_pkg::DESC_BAD :
            s == 8'h04 ? dtc_pkg::DESC_ASSIGN :
            s == 8'h05 ? dtc_pkg::DESC_UNASSIGN : dtc_pkg::DESC_GOOD;
         @(negedge ref_clk);
         data_wdata = (i < nsect) ? {s, d} : 16'h0000;
         data_write = 1'b1;
         @(negedge ref_clk);
         data_write = 1'b0;
         // Released bus shows the inverse so a stale word never looks valid
         data_wdata = ~data_wdata;
      end
   endtask

   task automatic read_words(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         data_read = 1'b1;
         @(negedge ref_clk);
         data_read = 1'b0;
      end
   endtask
endmodule

// ### test/dtc_engine_bench.sv
// Self-checking bench for the disk track command engine.
// Assumes a 40 MHz clock and a shortened diagnostic wait of 100 cycles.
`timescale 1ns/1ps
module dtc_engine_bench;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] cnt;
      logic [9:0] cyl;
      logic [7:0] err;
   } dtc_row_s;
   localparam int NROWS = 11;
   dtc_row_s rows [NROWS] = '{
      '{dtc_pkg::CMD_SEEK, 8'h01, 10'h00A, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_SEEK, 8'h01, 10'h2BC, dtc_pkg::ERR_IDNF},
      '{dtc_pkg::CMD_RDMUL, 8'h04, 10'h000, dtc_pkg::ERR_ABORT},
      '{dtc_pkg::CMD_SETMUL, 8'h03, 10'h000, dtc_pkg::ERR_ABORT},
      '{dtc_pkg::CMD_SETMUL, 8'h01, 10'h000, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_SETMUL, 8'h02, 10'h000, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_SETMUL, 8'h04, 10'h000, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_SETMUL, 8'h08, 10'h000, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_SETMUL, 8'h10, 10'h000, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_SETMUL, 8'h00, 10'h000, dtc_pkg::ERR_NONE},
      '{dtc_pkg::CMD_RDMUL, 8'h02, 10'h000, dtc_pkg::ERR_ABORT}};
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic is_master = 1'b1;
   logic slave_present = 1'b1;
   logic self_test_fail = 1'b0;
   logic slave_passed_line = 1'b0;
   logic seek_done = 1'b0;
   logic disk_error = 1'b0;
   logic disk_correctable = 1'b0;
   logic cmd_write, data_write, data_read, irq, seek_start, translate_mode;
   logic [7:0] cmd_code, error_reg, sectors_per_track;
   logic [15:0] data_wdata, data_rdata;
   logic [9:0] seek_cyl;
   logic [3:0] max_head;
   dtc_pkg::dtc_taskfile_s taskfile_in, taskfile_out;
   dtc_pkg::dtc_status_s status;
   int n_fail = 0;
   int num_checks = 0;
   int irq_cnt = 0;

   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (irq === 1'b1) irq_cnt++;

   dtc_host_model i_dtc_host_model (.ref_clk(ref_clk), .status(status),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .taskfile_in(taskfile_in),
      .data_write(data_write), .data_wdata(data_wdata),
      .data_read(data_read));
   dtc_engine #(.DIAG_WAIT(100)) i_dtc_engine (.ref_clk(ref_clk),
      .reset(reset), .cmd_write(cmd_write), .cmd_code(cmd_code),
      .taskfile_in(taskfile_in), .is_master(is_master),
      .slave_present(slave_present), .self_test_fail(self_test_fail),
      .slave_passed_line(slave_passed_line), .data_write(data_write),
      .data_wdata(data_wdata), .data_read(data_read),
      .seek_done(seek_done), .disk_error(disk_error),
      .disk_correctable(disk_correctable), .status(status),
      .error_reg(error_reg), .irq(irq), .data_rdata(data_rdata),
      .seek_start(seek_start), .seek_cyl(seek_cyl),
      .taskfile_out(taskfile_out), .translate_mode(translate_mode),
      .sectors_per_track(sectors_per_track), .max_head(max_head));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Bounded wait for the ending interrupt; a miss counts as a mismatch
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      chk({15'h0000, irq}, 16'h0001);
   endtask

   task automatic run_cmd(input logic [7:0] c, input logic [7:0] cnt,
         input logic [9:0] cyl, input logic [3:0] head);
      i_dtc_host_model.send_cmd(c, cnt, cyl, head);
      wait_irq(400);
   endtask

   task automatic end_seek();
      @(negedge ref_clk);
      seek_done = 1'b1;
      @(negedge ref_clk);
      seek_done = 1'b0;
   endtask

   task automatic format(input int nsect, input logic [7:0] err);
      i_dtc_host_model.send_cmd(dtc_pkg::CMD_FORMAT, 8'h00, 10'h005, 4'h1);
      wait (status.data_request_flag === 1'b1);
      i_dtc_host_model.write_block(nsect, 1'b1);
      wait_irq(200);
      chk({8'h00, error_reg}, {8'h00, err});
   endtask

   initial begin
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      chk({translate_mode, max_head, sectors_per_track}, 16'h1311);
      $display("test reset done");
      for (int r = 0; r < NROWS; r++) begin
         run_cmd(rows[r].cmd, rows[r].cnt, rows[r].cyl, 4'h0);
         chk({8'h00, error_reg}, {8'h00, rows[r].err});
         chk({15'h0000, status.error}, {15'h0000, |rows[r].err});
         chk({15'h0000, status.seek_complete}, {15'h0000, r != 0});
         end_seek();
      end
      $display("test table done");
      run_cmd(dtc_pkg::CMD_SEEK, 8'h01, 10'h014, 4'h0);
      i_dtc_host_model.send_cmd(dtc_pkg::CMD_INIT, 8'h08, 10'h000, 4'h5);
      repeat (20) @(negedge ref_clk);
      chk({15'h0000, status.busy_flag}, 16'h0001);
      end_seek();
      wait_irq(400);
      chk({translate_mode, max_head, sectors_per_track}, 16'h0508);
      $display("test queued init done");
      format(8, dtc_pkg::ERR_NONE);
      run_cmd(dtc_pkg::CMD_INIT, 8'h11, 10'h000, 4'h3);
      chk({15'h0000, translate_mode}, 16'h0001);
      format(16, dtc_pkg::ERR_IDNF);
      $display("test format done");
      run_cmd(dtc_pkg::CMD_SETMUL, 8'h02, 10'h000, 4'h0);
      @(negedge ref_clk);
      irq_cnt = 0;
      i_dtc_host_model.send_cmd(dtc_pkg::CMD_RDMUL, 8'h03, 10'h000, 4'h0);
      for (int b = 0; b < 2; b++) begin
         wait (status.data_request_flag === 1'b1);
         i_dtc_host_model.read_words(b == 0 ? 512 : 256);
      end
      repeat (4) @(negedge ref_clk);
      chk(16'(irq_cnt), 16'h0002);
      chk({15'h0000, status.data_request_flag}, 16'h0000);
      chk({8'h00, error_reg}, {8'h00, dtc_pkg::ERR_BADBLK});
      $display("test read multiple done");
      run_cmd(dtc_pkg::CMD_DIAG, 8'h00, 10'h000, 4'h0);
      chk({8'h00, error_reg}, 16'h0081);
      slave_passed_line = 1'b1;
      run_cmd(dtc_pkg::CMD_DIAG, 8'h00, 10'h000, 4'h0);
      chk({8'h00, error_reg}, 16'h0001);
      chk(16'(taskfile_out), 16'h0000);
      self_test_fail = 1'b1;
      run_cmd(dtc_pkg::CMD_DIAG, 8'h00, 10'h000, 4'h0);
      chk({8'h00, error_reg}, 16'h0003);
      $display("test diagnostic done");
      print_verdict();
   end

   initial begin
      #500000;
      n_fail++;
      print_verdict();
   end
endmodule
